// ==== design/wwd_pkg.sv ====
// windowed watchdog: constants, register map and types
// assumes a single register clock; oscillator tick arrives as a pin level
package wwd_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_WIN  = 2'h1;
    localparam logic [1:0] ADDR_STAT = 2'h2;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CHG_BIT  = 0;
    localparam int RUN_BIT  = 1;
    localparam int CODE_LSB = 2;
    localparam int CODE_MSB = 5;
    localparam int BUSY_BIT = 0;

    // ----------------------------------------
    // codes, counts and reset values
    // ----------------------------------------
    localparam logic [3:0]  CODE_MAX   = 4'hA;
    localparam logic [13:0] BASE_TICKS = 14'h0008;
    localparam logic [13:0] CNT_ONE    = 14'h0001;
    localparam logic [7:0]  RDATA_RST  = 8'h00;
    localparam logic [1:0]  RSVD_ZERO  = 2'h0;

    typedef enum logic {PH_CLOSED, PH_OPEN} wwd_phase_t;

    typedef struct packed {
        logic [3:0] per;
        logic       run;
        logic [3:0] wper;
        logic       wen;
    } wwd_cfg_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wwd_req_t;

    typedef struct packed {
        wwd_cfg_t   vis;
        wwd_cfg_t   act;
        logic       busy;
        logic [13:0] cnt;
        wwd_phase_t phase;
        logic       fire;
        logic [7:0] rdata;
        logic       tick_s1;
        logic       tick_s2;
        logic       tick_s3;
    } wwd_state_t;

    localparam wwd_state_t STATE_RST = '0;

endpackage

// ==== design/wwd_top.sv ====
// windowed watchdog: registers, config crossing and window counter
// assumes kick and unlock come from the core on REF_CLK; fuses are static
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module wwd_top (
    // clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       SYS_RST,
    // register port
    input  wire logic [1:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    // protection and restart
    input  wire logic       PROT_UNLOCK,
    input  wire logic       KICK,
    // oscillator tick, asynchronous
    input  wire logic       OSC_TICK,
    // fuses
    input  wire logic       FUSE_LOCK,
    input  wire logic       FUSE_RUN,
    input  wire logic       FUSE_WIN_EN,
    input  wire logic [3:0] FUSE_TIMEOUT,
    input  wire logic [3:0] FUSE_WINDOW,
    // reset request
    output logic            SYS_RESET_REQ
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic code_ok(input logic [3:0] code);
        return code <= wwd_pkg::CODE_MAX;
    endfunction

    function automatic logic [13:0] ticks_of(input logic [3:0] code);
        return 14'(wwd_pkg::BASE_TICKS << code);
    endfunction

    wwd_pkg::wwd_state_t st_q;
    wwd_pkg::wwd_state_t st_d;
    wwd_pkg::wwd_req_t   req;
    wwd_pkg::wwd_cfg_t   fuse_cfg;
    logic                tick;
    logic                wr_ok;
    logic                wr_ctrl;
    logic                wr_win;
    logic                accepted;
    logic                closed_live;
    logic [13:0]         cnt_inc;

    assign req      = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
    assign fuse_cfg = '{per: FUSE_TIMEOUT, run: FUSE_RUN,
                        wper: FUSE_WINDOW, wen: FUSE_WIN_EN};

    // rising edge taken from the second and third stages
    assign tick    = st_q.tick_s2 & ~st_q.tick_s3;
    assign wr_ok   = req.wr & PROT_UNLOCK;
    assign wr_ctrl = wr_ok && req.addr == wwd_pkg::ADDR_CTRL
                     && req.wdata[wwd_pkg::CHG_BIT] && !FUSE_LOCK;
    assign wr_win  = wr_ok && req.addr == wwd_pkg::ADDR_WIN
                     && req.wdata[wwd_pkg::CHG_BIT];
    assign accepted = wr_ctrl | wr_win;
    assign cnt_inc  = st_q.cnt + wwd_pkg::CNT_ONE;
    // invalid closed code means no closed period at all
    assign closed_live = st_q.act.wen && st_q.phase == wwd_pkg::PH_CLOSED
                         && code_ok(st_q.act.wper);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.fire    = 1'b0;
        st_d.rdata   = wwd_pkg::RDATA_RST;
        st_d.tick_s1 = OSC_TICK;
        st_d.tick_s2 = st_q.tick_s1;
        st_d.tick_s3 = st_q.tick_s2;

        if (wr_ctrl) begin
            st_d.vis.per = req.wdata[wwd_pkg::CODE_MSB:wwd_pkg::CODE_LSB];
            st_d.vis.run = req.wdata[wwd_pkg::RUN_BIT];
        end
        if (wr_win) begin
            st_d.vis.wen = req.wdata[wwd_pkg::RUN_BIT];
            if (!FUSE_LOCK) begin
                st_d.vis.wper = req.wdata[wwd_pkg::CODE_MSB:wwd_pkg::CODE_LSB];
            end
        end

        // while running, new config waits for the next tick; a write in the
        // same cycle as that tick keeps busy set so nothing is lost
        if (accepted && st_q.act.run) begin
            st_d.busy = 1'b1;
        end else if (accepted) begin
            st_d.act = st_d.vis;
        end else if (tick && st_q.busy) begin
            st_d.act  = st_q.vis;
            st_d.busy = 1'b0;
        end

        if (!st_q.act.run) begin
            st_d.cnt   = '0;
            st_d.phase = wwd_pkg::PH_CLOSED;
        end else if (KICK) begin
            st_d.fire  = closed_live;
            st_d.cnt   = '0;
            st_d.phase = wwd_pkg::PH_CLOSED;
        end else if (tick) begin
            if (closed_live) begin
                if (cnt_inc >= ticks_of(st_q.act.wper)) begin
                    st_d.cnt   = '0;
                    st_d.phase = wwd_pkg::PH_OPEN;
                end else begin
                    st_d.cnt = cnt_inc;
                end
            end else if (code_ok(st_q.act.per)) begin
                // open period or normal mode; expiry is the late case too
                if (cnt_inc >= ticks_of(st_q.act.per)) begin
                    st_d.fire  = 1'b1;
                    st_d.cnt   = '0;
                    st_d.phase = wwd_pkg::PH_CLOSED;
                end else begin
                    st_d.cnt = cnt_inc;
                end
            end
        end

        if (req.rd) begin
            case (req.addr)
                wwd_pkg::ADDR_CTRL: begin
                    st_d.rdata = {wwd_pkg::RSVD_ZERO, st_q.vis.per, st_q.vis.run, 1'b0};
                end
                wwd_pkg::ADDR_WIN: begin
                    st_d.rdata = {wwd_pkg::RSVD_ZERO, st_q.vis.wper, st_q.vis.wen, 1'b0};
                end
                wwd_pkg::ADDR_STAT: begin
                    st_d.rdata[wwd_pkg::BUSY_BIT] = st_q.busy;
                end
                default: begin
                    st_d.rdata = wwd_pkg::RDATA_RST;
                end
            endcase
        end
    end

    // fuses are static levels, caught by this clocked reset
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            st_q     <= wwd_pkg::STATE_RST;
            st_q.vis <= fuse_cfg;
            st_q.act <= fuse_cfg;
        end else begin
            st_q <= st_d;
        end
    end

    assign REG_RDATA     = st_q.rdata;
    assign SYS_RESET_REQ = st_q.fire;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_kick_normal;
        st_q.act.run && !st_q.act.wen && KICK;
    endsequence

    sequence s_cnt_cleared;
        st_q.cnt == 14'h0000;
    endsequence

    property p_kick_clears;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_kick_normal |=> s_cnt_cleared and !SYS_RESET_REQ;
    endproperty
    a_kick_clears: assert property (p_kick_clears) else $error("kick did not clear count");

    property p_early_kick;
        @(posedge REF_CLK) disable iff (SYS_RST)
        // a second kick inside the closed window pulses again, so no width check
        st_q.act.run && closed_live && KICK
        |=> SYS_RESET_REQ && st_q.cnt == 14'h0000 && st_q.phase == wwd_pkg::PH_CLOSED;
    endproperty
    a_early_kick: assert property (p_early_kick) else $error("early kick not punished");

    property p_open_follows;
        @(posedge REF_CLK) disable iff (SYS_RST)
        st_q.act.run && closed_live && tick && !KICK
        && cnt_inc == ticks_of(st_q.act.wper)
        |=> st_q.phase == wwd_pkg::PH_OPEN && st_q.cnt == 14'h0000 && !SYS_RESET_REQ;
    endproperty
    a_open_follows: assert property (p_open_follows) else $error("open did not follow closed");

    property p_timeout;
        @(posedge REF_CLK) disable iff (SYS_RST)
        st_q.act.run && !closed_live && tick && !KICK && code_ok(st_q.act.per)
        && cnt_inc == ticks_of(st_q.act.per) |=> SYS_RESET_REQ;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");

    property p_reserved_quiet;
        @(posedge REF_CLK) disable iff (SYS_RST)
        !st_q.act.wen && !code_ok(st_q.act.per) |=> !SYS_RESET_REQ;
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code fired");

    property p_count_on_tick;
        @(posedge REF_CLK) disable iff (SYS_RST)
        st_q.act.run && !KICK && !tick |=> $stable(st_q.cnt);
    endproperty
    a_count_on_tick: assert property (p_count_on_tick) else $error("count moved off tick");

    property p_lock_ctrl;
        @(posedge REF_CLK) disable iff (SYS_RST)
        FUSE_LOCK && req.wr |=> $stable(st_q.vis.per) && $stable(st_q.vis.run);
    endproperty
    a_lock_ctrl: assert property (p_lock_ctrl) else $error("locked control changed");

    property p_lock_win;
        @(posedge REF_CLK) disable iff (SYS_RST)
        FUSE_LOCK && wr_win
        |=> st_q.vis.wen == $past(req.wdata[wwd_pkg::RUN_BIT]) && $stable(st_q.vis.wper);
    endproperty
    a_lock_win: assert property (p_lock_win) else $error("window bits wrong under lock");

    property p_need_chg;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (req.wr && !req.wdata[wwd_pkg::CHG_BIT]) || (REG_WR && !PROT_UNLOCK)
        |=> $stable(st_q.vis);
    endproperty
    a_need_chg: assert property (p_need_chg) else $error("unqualified write landed");

    sequence s_busy_set;
        accepted && st_q.act.run;
    endsequence

    property p_busy;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_busy_set |=> st_q.busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag not held");

    property p_busy_clear;
        @(posedge REF_CLK) disable iff (SYS_RST)
        st_q.busy && tick && !accepted |=> !st_q.busy && st_q.act == $past(st_q.vis);
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("crossing did not finish");

    // ----------------------------------------
    // register port checks
    // ----------------------------------------
    // lock fuse blocks the control register and the window code field
    sequence s_ctrl_write;
        wr_ok && req.addr == wwd_pkg::ADDR_CTRL && req.wdata[wwd_pkg::CHG_BIT] && !FUSE_LOCK;
    endsequence

    sequence s_win_write;
        wr_ok && req.addr == wwd_pkg::ADDR_WIN && req.wdata[wwd_pkg::CHG_BIT];
    endsequence

    property p_busy_hold;
        @(posedge REF_CLK) disable iff (SYS_RST)
        st_q.busy && !tick |=> st_q.busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped before tick");

    property p_ctrl_write;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_ctrl_write |=> st_q.vis.run == $past(req.wdata[wwd_pkg::RUN_BIT])
            && st_q.vis.per == $past(req.wdata[wwd_pkg::CODE_MSB:wwd_pkg::CODE_LSB]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_win_write;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_win_write |=> st_q.vis.wen == $past(req.wdata[wwd_pkg::RUN_BIT]);
    endproperty
    a_win_write: assert property (p_win_write) else $error("window enable write lost");

    property p_apply_idle;
        @(posedge REF_CLK) disable iff (SYS_RST)
        accepted && !st_q.act.run |=> !st_q.busy && st_q.act == st_q.vis;
    endproperty
    a_apply_idle: assert property (p_apply_idle) else $error("idle write not applied");

    // offset 3 is unmapped and reads zero as well
    property p_read_zero;
        @(posedge REF_CLK) disable iff (SYS_RST)
        req.rd && req.addr != wwd_pkg::ADDR_STAT
        |=> (REG_RDATA >> (wwd_pkg::CODE_MSB + 1)) == 8'h00 && !REG_RDATA[wwd_pkg::CHG_BIT];
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("reserved bits read nonzero");

    property p_read_status;
        @(posedge REF_CLK) disable iff (SYS_RST)
        req.rd && req.addr == wwd_pkg::ADDR_STAT |=> REG_RDATA == {7'h00, $past(st_q.busy)};
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    // ----------------------------------------
    // counter checks
    // ----------------------------------------
    // no disable here: this one watches the reset itself
    property p_reset_load;
        @(posedge REF_CLK)
        SYS_RST |=> st_q.vis == $past(fuse_cfg) && st_q.act == $past(fuse_cfg)
            && !st_q.busy && !SYS_RESET_REQ && REG_RDATA == wwd_pkg::RDATA_RST;
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("reset did not load fuses");

    property p_stopped;
        @(posedge REF_CLK) disable iff (SYS_RST)
        !st_q.act.run |=> st_q.cnt == 14'h0000 && !SYS_RESET_REQ;
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped watchdog moved");

    property p_wper_rsvd;
        @(posedge REF_CLK) disable iff (SYS_RST)
        st_q.act.run && st_q.act.wen && !code_ok(st_q.act.wper) && KICK |=> !SYS_RESET_REQ;
    endproperty
    a_wper_rsvd: assert property (p_wper_rsvd) else $error("reserved closed code fired");

    property p_open_kick;
        @(posedge REF_CLK) disable iff (SYS_RST)
        st_q.act.run && st_q.act.wen && st_q.phase == wwd_pkg::PH_OPEN && KICK
        |=> !SYS_RESET_REQ && st_q.phase == wwd_pkg::PH_CLOSED && st_q.cnt == 14'h0000;
    endproperty
    a_open_kick: assert property (p_open_kick) else $error("open kick mishandled");

    // a synchronised tick below the limit advances the count by one
    property p_tick_advance;
        @(posedge REF_CLK) disable iff (SYS_RST)
        st_q.act.run && tick && !KICK && !closed_live && code_ok(st_q.act.per)
        && cnt_inc < ticks_of(st_q.act.per) |=> st_q.cnt == $past(cnt_inc);
    endproperty
    a_tick_advance: assert property (p_tick_advance) else $error("tick did not count");

    // every pulse needs a kick or a tick one cycle earlier
    property p_fire_cause;
        @(posedge REF_CLK) disable iff (SYS_RST)
        SYS_RESET_REQ |-> $past(KICK || tick);
    endproperty
    a_fire_cause: assert property (p_fire_cause) else $error("reset pulse without cause");

endmodule

// ==== tb/wwd_top_tb.sv ====
// windowed watchdog testbench: register tasks, tick and kick stimulus
// assumes design/wwd_pkg.sv and design/wwd_top.sv compiled first
`timescale 1ns/100ps
module wwd_top_tb;
    logic       ref_clk, sys_rst, reg_wr, reg_rd, prot_unlock, kick, osc_tick;
    logic       fuse_lock, fuse_run, fuse_win_en, sys_reset_req;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pulses, exp_p;
    logic [3:0] fuse_timeout, fuse_window;
    int         miscompares, tests_run;

    wwd_top dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .PROT_UNLOCK(prot_unlock), .KICK(kick), .OSC_TICK(osc_tick),
        .FUSE_LOCK(fuse_lock), .FUSE_RUN(fuse_run), .FUSE_WIN_EN(fuse_win_en),
        .FUSE_TIMEOUT(fuse_timeout), .FUSE_WINDOW(fuse_window),
        .SYS_RESET_REQ(sys_reset_req));

    // ----------------------------------------
    // clock, pulse counter, watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (sys_reset_req === 1'b1) begin
            pulses <= pulses + 8'h01;
        end
    end
    initial begin
        #50us;
        miscompares++;
        test_done();
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset(input logic lk, input logic rn, input logic wn,
                            input logic [3:0] to, input logic [3:0] wd);
        fuse_lock <= lk; fuse_run <= rn; fuse_win_en <= wn;
        fuse_timeout <= to; fuse_window <= wd; sys_rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
    endtask
    // unlock qualifies the strobe in the same cycle
    task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic u);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; prot_unlock <= u;
        @(posedge ref_clk);
        reg_wr <= 1'b0; prot_unlock <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge ref_clk);
    endtask
    // ticks run far faster than the real oscillator to keep the run short
    task automatic ticks(input int n);
        repeat (n) begin
            osc_tick <= 1'b1;
            repeat (4) @(posedge ref_clk);
            osc_tick <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    task automatic do_kick();
        kick <= 1'b1;
        @(posedge ref_clk);
        kick <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic pulses_are(input logic [7:0] n);
        exp_p = exp_p + n;
        #1 chk(pulses, exp_p);
    endtask
    task automatic test_done();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {sys_rst, reg_wr, reg_rd, prot_unlock, kick, osc_tick} = 6'h00;
        {fuse_lock, fuse_run, fuse_win_en} = 3'h0;
        {fuse_timeout, fuse_window, reg_addr, reg_wdata} = 18'h00000;
        {pulses, exp_p, miscompares, tests_run} = '0;
        do_reset(1'b0, 1'b0, 1'b0, 4'h3, 4'h5);
        rd(2'h0, 8'h0C);
        rd(2'h1, 8'h14);
        rd(2'h2, 8'h00);
        wr(2'h3, 8'hFF, 1'b1);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'h07, 1'b0);
        rd(2'h0, 8'h0C);
        wr(2'h0, 8'h06, 1'b1);
        rd(2'h0, 8'h0C);
        wr(2'h0, 8'h03, 1'b1);
        rd(2'h0, 8'h02);
        rd(2'h2, 8'h00);
        do_kick();
        repeat (200) @(posedge ref_clk);
        pulses_are(8'h00);
        ticks(7);
        do_kick();
        ticks(7);
        pulses_are(8'h00);
        ticks(1);
        pulses_are(8'h01);
        wr(2'h0, 8'h07, 1'b1);
        rd(2'h2, 8'h01);
        ticks(1);
        rd(2'h2, 8'h00);
        rd(2'h0, 8'h06);
        do_kick();
        ticks(15);
        pulses_are(8'h00);
        ticks(1);
        pulses_are(8'h01);
        wr(2'h0, 8'h2F, 1'b1);
        ticks(1);
        do_kick();
        ticks(20);
        pulses_are(8'h00);
        // stop while running: crosses on the next tick, then nothing counts
        wr(2'h0, 8'h01, 1'b1);
        rd(2'h2, 8'h01);
        ticks(12);
        rd(2'h2, 8'h00);
        pulses_are(8'h00);
        // window mode from a clean reset: closed 8, open 8
        do_reset(1'b0, 1'b1, 1'b1, 4'h0, 4'h0);
        ticks(10);
        do_kick();
        pulses_are(8'h00);
        ticks(3);
        do_kick();
        pulses_are(8'h01);
        ticks(15);
        pulses_are(8'h00);
        ticks(1);
        pulses_are(8'h01);
        wr(2'h1, 8'h2F, 1'b1);
        ticks(1);
        do_kick();
        pulses_are(8'h00);
        ticks(8);
        pulses_are(8'h01);
        wr(2'h1, 8'h00, 1'b1);
        rd(2'h1, 8'h2E);
        // lock fuse: control frozen, window enable still writable
        do_reset(1'b1, 1'b1, 1'b0, 4'h3, 4'h5);
        rd(2'h0, 8'h0E);
        wr(2'h0, 8'h01, 1'b1);
        rd(2'h0, 8'h0E);
        wr(2'h1, 8'h03, 1'b0);
        rd(2'h1, 8'h14);
        wr(2'h1, 8'h03, 1'b1);
        rd(2'h1, 8'h16);
        test_done();
    end
endmodule
